// File: inc/mpx_pkg.sv
// constants, types and helpers shared by the pin multiplexer files
`default_nettype none
package mpx_pkg;
   // system clock and clock output rates
   localparam int CLK_KHZ = 250000;
   localparam int CLKOUT_LO_KHZ = 13000;
   localparam int CLKOUT_HI_KHZ = 26000;
   localparam int ACC_W = 16;
   localparam logic [ACC_W-1:0] CLK_INC_LO =
      ACC_W'((64'(CLKOUT_LO_KHZ) << ACC_W) / 64'(CLK_KHZ));
   localparam logic [ACC_W-1:0] CLK_INC_HI =
      ACC_W'((64'(CLKOUT_HI_KHZ) << ACC_W) / 64'(CLK_KHZ));

   // network indication blink half periods
   localparam int NET_SLOW_HALF_MS = 500;
   localparam int NET_FAST_HALF_MS = 125;
   localparam int NET_SLOW_HALF_CYC = NET_SLOW_HALF_MS * CLK_KHZ;
   localparam int NET_FAST_HALF_CYC = NET_FAST_HALF_MS * CLK_KHZ;
   localparam int NET_CNT_W = 28;

   // pin indices
   localparam int NPINS = 9;
   localparam int GENERAL_PIN_ONE = 0;
   localparam int GENERAL_PIN_TWO = 1;
   localparam int GENERAL_PIN_THREE = 2;
   localparam int GENERAL_PIN_FOUR = 3;
   localparam int GENERAL_PIN_FIVE = 4;
   localparam int AUDIO_TXD_PIN = 5;
   localparam int AUDIO_RXD_PIN = 6;
   localparam int AUDIO_CLK_PIN = 7;
   localparam int AUDIO_WORD_ALIGN_PIN = 8;
   localparam int LAST_NET_PIN = GENERAL_PIN_FOUR;
   localparam int FIRST_AUDIO_PIN = AUDIO_TXD_PIN;

   // register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int FUNC_W = 4;
   localparam logic [ADDR_W-1:0] REG_FUNC0 = 4'h0;
   localparam logic [ADDR_W-1:0] REG_OUT = 4'h9;
   localparam logic [ADDR_W-1:0] REG_IN = 4'hA;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'hB;
   localparam logic [ADDR_W-1:0] REG_STAT = 4'hC;

   // control register fields
   localparam int CTRL_AUDIO_GRP = 0;
   localparam int CTRL_GNSS_SUP = 1;
   localparam int CTRL_NET_LSB = 2;
   localparam int CTRL_CLK_EN = 4;
   localparam int CTRL_CLK_HI = 5;
   localparam int CTRL_CLK_CONT = 6;
   localparam int CTRL_W = 7;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h01;

   // status register fields
   localparam int ST_SIM_PRES = 0;
   localparam int ST_SIM_EN = 1;
   localparam int ST_GNSS_RDY = 2;
   localparam int ST_EVT_LSB = 3;
   localparam int EVT_W = 3;
   localparam int EVT_INS = 0;
   localparam int EVT_REM = 1;
   localparam int EVT_RDY = 2;

   typedef enum logic [FUNC_W-1:0] {
      F_DISABLED, F_GP_IN, F_GP_OUT, F_NET_STATUS, F_GNSS_SUPPLY,
      F_GNSS_READY, F_RTC_SYNC, F_SIM_DETECT, F_SIM_HOTPLUG, F_AUDIO
   } mpx_func_type;

   typedef enum logic [1:0] {
      NET_NO_SERVICE, NET_HOME, NET_ROAMING, NET_DATA
   } mpx_net_type;

   localparam mpx_func_type FUNC_RESET [NPINS] = '{
      F_DISABLED, F_GNSS_SUPPLY, F_GNSS_READY, F_GP_OUT, F_SIM_DETECT,
      F_DISABLED, F_DISABLED, F_DISABLED, F_DISABLED};

   // which function codes a pin's own select register may take
   function automatic logic func_legal(input int idx, input mpx_func_type f);
      logic ok;
      ok = 1'h0;
      case (f)
         F_DISABLED, F_GP_IN, F_GP_OUT: ok = 1'h1;
         F_NET_STATUS, F_GNSS_SUPPLY: ok = (idx <= LAST_NET_PIN);
         F_GNSS_READY: ok = (idx == GENERAL_PIN_THREE);
         F_RTC_SYNC: ok = (idx == GENERAL_PIN_FOUR);
         F_SIM_DETECT, F_SIM_HOTPLUG: ok = (idx == GENERAL_PIN_FIVE);
         default: ok = 1'h0;
      endcase
      return ok;
   endfunction
endpackage
`default_nettype wire

// File: rtl/mpx_clk_gen.sv
// phase accumulator square wave for the clock output pin
`default_nettype none
module mpx_clk_gen
   import mpx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [ACC_W-1:0] inc,
   output logic clk_out
);
   logic [ACC_W-1:0] acc_r;

   // neither rate divides the system clock, so edges carry one cycle of jitter;
   // stopping clears the phase so the pin rests low
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !run) begin
         acc_r <= '0;
      end else begin
         acc_r <= acc_r + inc;
      end
   end

   assign clk_out = acc_r[ACC_W-1];
endmodule
`default_nettype wire

// File: rtl/mpx_pin_mux.sv
// multifunction pin multiplexer with selectable clock output
//
// The address map and the plain strobed port are this design's own decisions.
`default_nettype none
module mpx_pin_mux
   import mpx_pkg::*;
#(
   parameter int NET_SLOW_CYC = NET_SLOW_HALF_CYC,
   parameter int NET_FAST_CYC = NET_FAST_HALF_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [NPINS-1:0] pin_in,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe,
   output logic [NPINS-1:0] pin_pd_en,
   output logic clock_output_pin_o,
   input wire logic audio_path_active,
   input wire logic rtc_sync_src,
   input wire logic aud_txd,
   output logic aud_rxd,
   input wire logic aud_clk_o,
   input wire logic aud_clk_oe,
   output logic aud_clk_i,
   input wire logic aud_wa_o,
   input wire logic aud_wa_oe,
   output logic aud_wa_i,
   output logic gnss_data_ready,
   output logic sim_present,
   output logic sim_if_enable
);
   mpx_func_type func_r [NPINS];
   mpx_func_type eff [NPINS];
   mpx_func_type eff_prev_r [NPINS];
   mpx_net_type net_state;
   logic [NPINS-1:0] out_val_r;
   logic [NPINS-1:0] pin_sync;
   logic [NPINS-1:0] drv_o;
   logic [NPINS-1:0] drv_oe;
   logic [NPINS-1:0] drv_pd;
   logic [NPINS-1:0] pin_out_r;
   logic [NPINS-1:0] pin_oe_r;
   logic [NPINS-1:0] pin_pd_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [EVT_W-1:0] evt_r;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] stat_word;
   logic [NET_CNT_W-1:0] net_cnt_r;
   logic [NET_CNT_W-1:0] net_half;
   logic net_tick;
   logic blink_r;
   logic net_lvl_r;
   logic audio_on;
   logic sim_fn;
   logic hot_fn;
   logic rdy_fn;
   logic sim_pres_d_r;
   logic sim_ins;
   logic sim_rem;
   logic sim_pres_r;
   logic sim_en_r;
   logic rdy_d_r;
   logic rdy_r;
   logic aud_rxd_r;
   logic aud_clk_i_r;
   logic aud_wa_i_r;
   logic clk_run;
   logic [ACC_W-1:0] clk_inc;

   // pins come from outside, so every one is synchronised first
   mpx_sync #(
      .W(NPINS)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d(pin_in),
      .q(pin_sync)
   );

   // select registers
   // a write with a code this pin cannot carry is dropped, old choice kept
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NPINS; i++) begin
            func_r[i] <= FUNC_RESET[i];
         end
      end else begin
         for (int i = 0; i < NPINS; i++) begin
            if (reg_wr && reg_addr == REG_FUNC0 + ADDR_W'(i) &&
                func_legal(i, mpx_func_type'(reg_wdata[FUNC_W-1:0]))) begin
               func_r[i] <= mpx_func_type'(reg_wdata[FUNC_W-1:0]);
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         out_val_r <= '0;
      end else if (reg_wr && reg_addr == REG_OUT) begin
         out_val_r <= reg_wdata[NPINS-1:0];
      end
   end

   // control: audio group, GNSS supply, network state, clock output setup
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RESET;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         ctrl_r <= reg_wdata[CTRL_W-1:0];
      end
   end

   assign net_state = mpx_net_type'(ctrl_r[CTRL_NET_LSB +: 2]);
   assign audio_on = ctrl_r[CTRL_AUDIO_GRP];

   // group audio override
   // the four audio pins follow one bit, so they never split between roles
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         eff[i] = (i >= FIRST_AUDIO_PIN && audio_on) ? F_AUDIO : func_r[i];
      end
   end

   always_comb begin
      drv_o = '0;
      drv_oe = '0;
      drv_pd = '0;
      for (int i = 0; i < NPINS; i++) begin
         case (eff[i])
            F_DISABLED: drv_pd[i] = 1'h1;
            F_GP_OUT: begin
               drv_o[i] = out_val_r[i];
               drv_oe[i] = 1'h1;
            end
            F_NET_STATUS: begin
               drv_o[i] = net_lvl_r;
               drv_oe[i] = 1'h1;
            end
            F_GNSS_SUPPLY: begin
               drv_o[i] = ctrl_r[CTRL_GNSS_SUP];
               drv_oe[i] = 1'h1;
            end
            F_RTC_SYNC: begin
               drv_o[i] = rtc_sync_src;
               drv_oe[i] = 1'h1;
            end
            F_AUDIO: begin
               if (i == AUDIO_TXD_PIN) begin
                  drv_o[i] = aud_txd;
                  drv_oe[i] = 1'h1;
               end else if (i == AUDIO_CLK_PIN) begin
                  drv_o[i] = aud_clk_o;
                  drv_oe[i] = aud_clk_oe;
               end else if (i == AUDIO_WORD_ALIGN_PIN) begin
                  drv_o[i] = aud_wa_o;
                  drv_oe[i] = aud_wa_oe;
               end
            end
            default: drv_oe[i] = 1'h0;
         endcase
      end
   end

   // detach on change
   // a changed function leaves the pin undriven one cycle before the new one drives
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pin_out_r <= '0;
         pin_oe_r <= '0;
         pin_pd_r <= '1;
         for (int i = 0; i < NPINS; i++) begin
            eff_prev_r[i] <= F_DISABLED;
         end
      end else begin
         pin_out_r <= drv_o;
         pin_pd_r <= drv_pd;
         for (int i = 0; i < NPINS; i++) begin
            pin_oe_r[i] <= drv_oe[i] && (eff[i] == eff_prev_r[i]);
            eff_prev_r[i] <= eff[i];
         end
      end
   end

   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;
   assign pin_pd_en = pin_pd_r;

   // network blink divider
   // one-cycle tick paces the blink; home blinks slow, roaming fast
   assign net_half = (net_state == NET_HOME) ? NET_CNT_W'(NET_SLOW_CYC - 1) :
                     NET_CNT_W'(NET_FAST_CYC - 1);
   assign net_tick = (net_cnt_r >= net_half);

   always_ff @(posedge sys_clk) begin
      if (!rst_n || net_tick) begin
         net_cnt_r <= '0;
      end else begin
         net_cnt_r <= net_cnt_r + NET_CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         blink_r <= 1'h0;
      end else if (net_tick) begin
         blink_r <= ~blink_r;
      end
   end

   // four network states on one level
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         net_lvl_r <= 1'h0;
      end else begin
         case (net_state)
            NET_NO_SERVICE: net_lvl_r <= 1'h0;
            NET_HOME, NET_ROAMING: net_lvl_r <= blink_r;
            NET_DATA: net_lvl_r <= 1'h1;
            default: net_lvl_r <= 1'h0;
         endcase
      end
   end

   assign sim_fn = (eff[GENERAL_PIN_FIVE] == F_SIM_DETECT) || hot_fn;
   assign hot_fn = (eff[GENERAL_PIN_FIVE] == F_SIM_HOTPLUG);
   assign sim_ins = sim_fn && pin_sync[GENERAL_PIN_FIVE] && !sim_pres_d_r;
   assign sim_rem = sim_fn && !pin_sync[GENERAL_PIN_FIVE] && sim_pres_d_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sim_pres_d_r <= 1'h0;
         sim_pres_r <= 1'h0;
      end else begin
         sim_pres_d_r <= pin_sync[GENERAL_PIN_FIVE];
         sim_pres_r <= sim_fn && pin_sync[GENERAL_PIN_FIVE];
      end
   end

   // hot plug gates SIM interface
   // without hot plug the interface is simply left enabled
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !hot_fn) begin
         sim_en_r <= 1'h1;
      end else if (sim_ins) begin
         sim_en_r <= 1'h1;
      end else if (sim_rem) begin
         sim_en_r <= 1'h0;
      end
   end

   assign rdy_fn = (eff[GENERAL_PIN_THREE] == F_GNSS_READY);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdy_r <= 1'h0;
         rdy_d_r <= 1'h0;
      end else begin
         rdy_r <= rdy_fn && pin_sync[GENERAL_PIN_THREE];
         rdy_d_r <= rdy_r;
      end
   end

   assign sim_present = sim_pres_r;
   assign sim_if_enable = sim_en_r;
   assign gnss_data_ready = rdy_r;

   // sticky events, write one to clear; a new event beats its clear
   assign evt_set = {rdy_r && !rdy_d_r, sim_rem, sim_ins};
   assign evt_clr = (reg_wr && reg_addr == REG_STAT) ?
                    reg_wdata[ST_EVT_LSB +: EVT_W] : '0;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         evt_r <= '0;
      end else begin
         evt_r <= (evt_r & ~evt_clr) | evt_set;
      end
   end

   // audio input pins handed to the audio port, zero when not selected
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aud_rxd_r <= 1'h0;
         aud_clk_i_r <= 1'h0;
         aud_wa_i_r <= 1'h0;
      end else begin
         aud_rxd_r <= audio_on && pin_sync[AUDIO_RXD_PIN];
         aud_clk_i_r <= audio_on && pin_sync[AUDIO_CLK_PIN];
         aud_wa_i_r <= audio_on && pin_sync[AUDIO_WORD_ALIGN_PIN];
      end
   end

   assign aud_rxd = aud_rxd_r;
   assign aud_clk_i = aud_clk_i_r;
   assign aud_wa_i = aud_wa_i_r;

   assign clk_run = ctrl_r[CTRL_CLK_EN] &&
                    (ctrl_r[CTRL_CLK_CONT] || audio_path_active);
   assign clk_inc = ctrl_r[CTRL_CLK_HI] ? CLK_INC_HI : CLK_INC_LO;

   mpx_clk_gen u_clk_gen (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .run(clk_run),
      .inc(clk_inc),
      .clk_out(clock_output_pin_o)
   );

   // status word layout
   always_comb begin
      stat_word = '0;
      stat_word[ST_SIM_PRES] = sim_pres_r;
      stat_word[ST_SIM_EN] = sim_en_r;
      stat_word[ST_GNSS_RDY] = rdy_r;
      stat_word[ST_EVT_LSB +: EVT_W] = evt_r;
   end

   // read path
   // data stand for exactly one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !reg_rd) begin
         rdata_r <= '0;
      end else if (reg_addr < REG_OUT) begin
         rdata_r <= DATA_W'(func_r[int'(reg_addr)]);
      end else begin
         case (reg_addr)
            REG_OUT: rdata_r <= DATA_W'(out_val_r);
            REG_IN: rdata_r <= DATA_W'(pin_sync);
            REG_CTRL: rdata_r <= DATA_W'(ctrl_r);
            REG_STAT: rdata_r <= stat_word;
            default: rdata_r <= '0;
         endcase
      end
   end

   assign reg_rdata = rdata_r;

   default clocking mpx_cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_hi_rise;
      $rose(clock_output_pin_o) && clk_run && ctrl_r[CTRL_CLK_HI] && $stable(clk_inc);
   endsequence

   sequence s_lo_rise;
      $rose(clock_output_pin_o) && clk_run && !ctrl_r[CTRL_CLK_HI] && $stable(clk_inc);
   endsequence

   clk_hi_rate_a: assert property (s_hi_rise |-> ##[4:5]
      ($fell(clock_output_pin_o) || !clk_run || !ctrl_r[CTRL_CLK_HI]))
      else $error("26 MHz high phase has wrong length");

   clk_lo_rate_a: assert property (s_lo_rise |-> ##[9:10]
      ($fell(clock_output_pin_o) || !clk_run || ctrl_r[CTRL_CLK_HI]))
      else $error("13 MHz high phase has wrong length");

   clk_idle_a: assert property (!clk_run |=> !clock_output_pin_o)
      else $error("clock output not idle while gated");

   net_pin_range_a: assert property (
      func_r[GENERAL_PIN_FIVE] != F_NET_STATUS &&
      func_r[GENERAL_PIN_FIVE] != F_GNSS_SUPPLY)
      else $error("network or supply function on pin five");

   ready_pin_only_a: assert property (
      func_r[GENERAL_PIN_ONE] != F_GNSS_READY && func_r[GENERAL_PIN_TWO] != F_GNSS_READY &&
      func_r[GENERAL_PIN_FOUR] != F_GNSS_READY && func_r[GENERAL_PIN_FIVE] != F_GNSS_READY)
      else $error("data ready sense outside pin three");

   rtc_pin_only_a: assert property (
      func_r[GENERAL_PIN_ONE] != F_RTC_SYNC && func_r[GENERAL_PIN_TWO] != F_RTC_SYNC &&
      func_r[GENERAL_PIN_THREE] != F_RTC_SYNC && func_r[GENERAL_PIN_FIVE] != F_RTC_SYNC)
      else $error("rtc sync outside pin four");

   hot_insert_a: assert property (hot_fn && sim_ins |=> sim_if_enable)
      else $error("sim interface not enabled on insertion");

   hot_remove_a: assert property (hot_fn && sim_rem |=> !sim_if_enable)
      else $error("sim interface not disabled on removal");

   sticky_set_a: assert property (sim_ins |=> evt_r[EVT_INS])
      else $error("insertion event lost");

   gp_in_read_a: assert property (
      reg_rd && reg_addr == REG_IN |=> reg_rdata[NPINS-1:0] == $past(pin_sync))
      else $error("input readback does not match pins");

   gp_out_drive_a: assert property ((rst_n && eff[GENERAL_PIN_FOUR] == F_GP_OUT) [*2] |=>
      pin_oe[GENERAL_PIN_FOUR] && pin_out[GENERAL_PIN_FOUR] == $past(out_val_r[GENERAL_PIN_FOUR]))
      else $error("general output level not driven");

   disabled_pd_a: assert property (eff[GENERAL_PIN_ONE] == F_DISABLED |=>
      pin_pd_en[GENERAL_PIN_ONE] && !pin_oe[GENERAL_PIN_ONE])
      else $error("disabled pin not floating with pull-down");

   detach_gap_a: assert property ($changed(eff[GENERAL_PIN_FOUR]) |=>
      !pin_oe[GENERAL_PIN_FOUR])
      else $error("new function drove without a detach cycle");
endmodule
`default_nettype wire

// File: rtl/mpx_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module mpx_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // meta_r feeds only the second stage
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// File: verification/mpx_far_end.sv
// far side model: SIM holder, GNSS receiver and generic pin drivers
`default_nettype none
module mpx_far_end
   import mpx_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [NPINS-1:0] pin_out,
   input wire logic [NPINS-1:0] pin_oe,
   input wire logic [NPINS-1:0] pin_pd_en,
   input wire logic [NPINS-1:0] ext_drv,
   input wire logic [NPINS-1:0] ext_lvl,
   input wire logic card_in,
   input wire logic gnss_rdy,
   output logic [NPINS-1:0] pin_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flip_r;
   // a floating pin with no pull wanders, so it never reads as a stable level
   initial flip_r = 1'h0;
   always @(posedge sys_clk) begin
      flip_r <= ~flip_r;
   end
   // wire level from all enables; card and receiver own pins five and three
   // pull-down level
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (pin_oe[i]) pin_wire[i] = pin_out[i];
         else if (i == GENERAL_PIN_FIVE) pin_wire[i] = card_in;
         else if (i == GENERAL_PIN_THREE) pin_wire[i] = gnss_rdy;
         else if (ext_drv[i]) pin_wire[i] = ext_lvl[i];
         else if (pin_pd_en[i]) pin_wire[i] = 1'h0;
         else pin_wire[i] = flip_r;
      end
   end
endmodule
`default_nettype wire

// File: verification/tb_mpx_pin_mux.sv
// self-checking bench for the pin multiplexer and clock output
`default_nettype none
module tb_mpx_pin_mux
   import mpx_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [3:0] a; logic w; logic [31:0] d; logic [31:0] e;} mpx_row_type;
   logic sys_clk, rst_n, reg_wr, reg_rd, clock_output_pin_o, audio_path_active;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, got;
   logic [NPINS-1:0] pin_wire, pin_out, pin_oe, pin_pd_en, ext_drv, ext_lvl;
   logic rtc_sync_src, aud_txd, aud_rxd, aud_clk_o, aud_clk_oe, aud_clk_i;
   logic aud_wa_o, aud_wa_oe, aud_wa_i, gnss_data_ready, sim_present, sim_if_enable;
   logic card_in, gnss_rdy;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   // register rows: address, write flag, write data, expected read back
   mpx_row_type rows [15] = '{
      '{4'h0, 1'h0, 32'h0, 32'h0}, // pin one off
      '{4'h1, 1'h0, 32'h0, 32'h4}, // supply default
      '{4'h2, 1'h0, 32'h0, 32'h5}, // ready default
      '{4'h3, 1'h0, 32'h0, 32'h2}, // output default
      '{4'h4, 1'h0, 32'h0, 32'h7}, // detect default
      '{4'hB, 1'h0, 32'h0, 32'h1}, // audio default
      '{4'h0, 1'h1, 32'h5, 32'h0}, // refused elsewhere
      '{4'h4, 1'h1, 32'h6, 32'h7}, // refused elsewhere
      '{4'h4, 1'h1, 32'h3, 32'h7}, // refused on five
      '{4'h3, 1'h1, 32'h6, 32'h6}, // accepted on four
      '{4'h0, 1'h1, 32'h3, 32'h3}, // accepted on one
      '{4'h2, 1'h1, 32'h4, 32'h4}, // accepted on three
      '{4'hF, 1'h1, 32'h5, 32'h0}, // unmapped
      '{4'h9, 1'h1, 32'hFFFFFFFF, 32'h1FF}, // nine levels
      '{4'h0, 1'h1, 32'h9, 32'h3}}; // not per pin

   mpx_pin_mux #(.NET_SLOW_CYC(40), .NET_FAST_CYC(10)) u_dut (
      .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .pin_in(pin_wire), .pin_out, .pin_oe, .pin_pd_en, .clock_output_pin_o,
      .audio_path_active, .rtc_sync_src, .aud_txd, .aud_rxd, .aud_clk_o,
      .aud_clk_oe, .aud_clk_i, .aud_wa_o, .aud_wa_oe, .aud_wa_i,
      .gnss_data_ready, .sim_present, .sim_if_enable);

   mpx_far_end u_far (.sys_clk, .pin_out, .pin_oe, .pin_pd_en, .ext_drv, .ext_lvl,
      .card_in, .gnss_rdy, .pin_wire);

   initial begin
      sys_clk = 1'h0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // a hang is cut short well above the expected run length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // each strobe starts on a fresh edge, so no signal is assigned twice in one step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask

   // read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask

   // counts toggles of net pin one (sel 0) or the clock pin (sel 1), one of slack
   task automatic tog(input bit sel, input int n, input int e);
      logic p;
      logic v;
      int t;
      t = 0;
      cyc(4);
      #1 p = sel ? clock_output_pin_o : pin_out[0];
      repeat (n) begin
         @(posedge sys_clk);
         #1 v = sel ? clock_output_pin_o : pin_out[0];
         t += int'(v !== p);
         p = v;
      end
      chk(32'((t - e) inside {[-1:1]}), 32'h1, "toggle count");
   endtask

   initial begin
      rst_n = 1'h0;
      {reg_wr, reg_rd, audio_path_active, rtc_sync_src, card_in, gnss_rdy} = '0;
      {aud_txd, aud_clk_o, aud_clk_oe, aud_wa_o, aud_wa_oe} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      ext_drv = '0;
      ext_lvl = '0;
      cyc(6);
      #1 chk(32'({pin_pd_en, sim_if_enable}), 32'h3FF, "reset levels"); // reset pulls
      cyc(2);
      rst_n <= 1'h1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, got);
         chk(got, rows[i].e, "register row"); // each row alone
      end
      // all nine pins as outputs, audio group off
      wr(REG_CTRL, 32'h0);
      for (int i = 0; i < NPINS; i++) wr(4'(i), 32'h2);
      wr(REG_OUT, 32'h1A5);
      cyc(4);
      #1 chk(32'({pin_oe, pin_out}), 32'h3FFA5, "general out"); // drives level
      for (int i = 0; i < NPINS; i++) wr(4'(i), 32'h1);
      ext_drv <= 9'h1FF;
      ext_lvl <= 9'h0C3;
      cyc(4);
      rd(REG_IN, got);
      chk(got, 32'h0C3, "general in"); // sampled level
      chk(32'(pin_oe), 32'h0, "inputs float"); // no drive
      wr(4'h0, 32'h0);
      ext_drv <= 9'h0;
      cyc(4);
      rd(REG_IN, got);
      chk(32'({pin_pd_en, got[0]}), 32'h2, "disabled pin"); // pull-down only
      // function change detaches before the new drive
      wr(4'h3, 32'h2);
      wr(REG_OUT, 32'h008);
      cyc(3);
      wr(4'h3, 32'h6);
      cyc(1);
      #1 chk(32'(pin_oe[3]), 32'h0, "detach"); // one gap cycle
      cyc(1);
      #1 chk(32'({pin_oe[3], pin_out[3]}), 32'h2, "rtc drive"); // then drive
      cyc(1);
      rtc_sync_src <= 1'h1;
      cyc(3);
      #1 chk(32'(pin_out[3]), 32'h1, "rtc level"); // follows source
      // network states on pin one: none, home, roaming, data
      wr(4'h0, 32'h3);
      wr(REG_CTRL, 32'h0);
      tog(1'h0, 80, 0); // no service
      chk(32'(pin_out[0]), 32'h0, "no service"); // low
      wr(REG_CTRL, 32'h4);
      tog(1'h0, 80, 2); // home slow
      wr(REG_CTRL, 32'h8);
      tog(1'h0, 80, 8); // roaming fast
      wr(REG_CTRL, 32'hC);
      tog(1'h0, 80, 0); // data steady
      chk(32'(pin_out[0]), 32'h1, "data state"); // high
      // clock output rates and gating
      wr(REG_CTRL, 32'h70);
      tog(1'h1, 500, 104); // 26 MHz
      wr(REG_CTRL, 32'h50);
      tog(1'h1, 500, 52); // 13 MHz
      wr(REG_CTRL, 32'h30);
      tog(1'h1, 300, 0); // audio idle
      @(posedge sys_clk) audio_path_active <= 1'h1;
      tog(1'h1, 500, 104); // audio running
      // receiver supply and data ready
      wr(4'h1, 32'h4);
      wr(REG_CTRL, 32'h2);
      cyc(4);
      #1 chk(32'({pin_oe[1], pin_out[1]}), 32'h3, "supply on"); // enable drive
      wr(4'h2, 32'h5);
      gnss_rdy <= 1'h1;
      cyc(5);
      #1 chk(32'(gnss_data_ready), 32'h1, "ready level"); // sensed
      rd(REG_STAT, got);
      chk(32'({got[ST_GNSS_RDY], got[ST_EVT_LSB+EVT_RDY]}), 32'h3, "ready stat");
      // card hot plug, then plain detection
      wr(4'h4, 32'h8);
      cyc(5);
      // only a detected edge moves the interface, so an empty holder leaves it on
      #1 chk(32'(sim_if_enable), 32'h1, "no removal yet"); // edges only
      cyc(1);
      card_in <= 1'h1;
      cyc(5);
      #1 chk(32'({sim_present, sim_if_enable}), 32'h3, "inserted"); // interface on
      rd(REG_STAT, got);
      chk(32'(got[ST_EVT_LSB+EVT_INS]), 32'h1, "insert event"); // seen
      @(posedge sys_clk) card_in <= 1'h0;
      cyc(5);
      #1 chk(32'({sim_present, sim_if_enable}), 32'h0, "removed hot"); // interface off
      rd(REG_STAT, got);
      chk(32'(got[ST_EVT_LSB +: EVT_W]), 32'h7, "events"); // all sticky
      wr(REG_STAT, 32'h18);
      rd(REG_STAT, got);
      chk(32'(got[ST_EVT_LSB +: EVT_W]), 32'h4, "event clear"); // one clears
      wr(4'h4, 32'h7);
      cyc(5);
      #1 chk(32'({sim_present, sim_if_enable}), 32'h1, "removed"); // presence
      // audio group on, then back to per-pin functions
      wr(REG_CTRL, 32'h1);
      {aud_txd, aud_clk_oe, aud_clk_o, aud_wa_oe, aud_wa_o} <= 5'h1F;
      ext_drv <= 9'h040;
      ext_lvl <= 9'h040;
      cyc(6);
      #1 chk(32'({pin_oe[8:7], pin_out[8:7], pin_oe[5], pin_out[5]}), 32'h3F, "audio");
      chk(32'({aud_rxd, aud_clk_i, aud_wa_i}), 32'h7, "audio in");
      wr(REG_CTRL, 32'h0);
      cyc(4);
      #1 chk(32'(pin_oe[8:5]), 32'h0, "audio off"); // group leaves
      tally_and_finish();
   end
endmodule
`default_nettype wire
